// ==== core/rail_enable_sequence_regs.sv ====
/*
 Rail enable, lockout threshold and buck strobe assignment registers.
 Assumes a serial-bus front end on sys_clk presents byte accesses and a
 password-unlock flag; the power request pin is asynchronous.
*/
// Behaviour
// - Rail enable at 0x16, reset zero, bit7 zero
// - Bit6 switch A, needs power pin high
// - Bit5 switch B, needs power pin high
// - Bits4..2 bucks A..C, need power pin
// - One enables; bits1,0 drive linear regulators directly
// - Writes refused unless password unlock granted
// - Lockout at 0x18 selects threshold bits1:0
// - Lockout bits7:3 read zero, bit2 writable
// - Strobe assign at 0x19: buck A 6:4, B 2:0
// - Code zero keeps rail outside sequencer
// - Codes one..seven enable at that strobe
// - Strobe assign bits 7 and 3 read zero
`timescale 1ns/1ps
module rail_enable_sequence_regs
   import rail_regs_pkg::*;
(
   // Clock and control
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire logic                   clkEn,
   // Register access from the serial front end
   input  wire rail_regs_pkg::reg_req_s regReq,
   input  wire logic                   writeUnlocked,
   output rail_regs_pkg::byte_t        rdData,
   output logic                        rdValid,
   output logic                        wrRejected,
   // Sequencer strobes
   input  wire logic                   seqRestart,
   input  wire logic                   strobeValid,
   input  wire rail_regs_pkg::slot_t   strobeStep,
   // Pin and rail controls
   input  wire logic                   power_request_pin,
   output rail_regs_pkg::rail_on_s     railOn,
   output logic [1:0]                  lockoutThresholdSel
);
   typedef struct packed {
      byte_t    railEnable;
      byte_t    lockout;
      byte_t    strobeAssign;
      logic     pinMeta;
      logic     pinSync;
      byte_t    rdData;
      logic     rdValid;
      logic     wrRejected;
      rail_on_s railOn;
   } regs_s;
   regs_s st_q, st_d;

   logic  buckASeqOn, buckBSeqOn, buckAOwned, buckBOwned;
   slot_t buckASlot, buckBSlot;

   assign buckASlot = st_q.strobeAssign[SLOT_A_LSB +: SLOT_W];
   assign buckBSlot = st_q.strobeAssign[SLOT_B_LSB +: SLOT_W];

   strobe_slot_gate u_gate_a (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .clkEn       (clkEn),
      .seqRestart  (seqRestart),
      .strobeValid (strobeValid),
      .strobeStep  (strobeStep),
      .slot        (buckASlot),
      .seqOn       (buckASeqOn),
      .seqOwned    (buckAOwned)
   );

   strobe_slot_gate u_gate_b (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .clkEn       (clkEn),
      .seqRestart  (seqRestart),
      .strobeValid (strobeValid),
      .strobeStep  (strobeStep),
      .slot        (buckBSlot),
      .seqOn       (buckBSeqOn),
      .seqOwned    (buckBOwned)
   );

   always_comb begin
      logic  pinHigh;
      logic  hit;
      byte_t rd;
      pinHigh = 1'b0;
      hit     = 1'b0;
      rd      = 8'h00;
      st_d    = st_q;
      // Pin is asynchronous: two flops before use
      st_d.pinMeta    = power_request_pin;
      st_d.pinSync    = st_q.pinMeta;
      pinHigh         = st_q.pinSync;
      st_d.rdValid    = 1'b0;
      st_d.wrRejected = 1'b0;

      unique case (regReq.addr)
         RAIL_ENABLE_CONTROL_OFS: begin
            hit = 1'b1;
            rd  = st_q.railEnable & RAIL_ENABLE_WMASK;
         end
         LOCKOUT_THRESHOLD_CONTROL_OFS: begin
            hit = 1'b1;
            rd  = st_q.lockout & LOCKOUT_WMASK;
         end
         BUCK_STROBE_ASSIGN_A_OFS: begin
            hit = 1'b1;
            rd  = st_q.strobeAssign & STROBE_ASSIGN_WMASK;
         end
         default: begin
            hit = 1'b0;
            rd  = 8'h00;
         end
      endcase

      if (regReq.rdEn) begin
         st_d.rdData  = rd;
         st_d.rdValid = 1'b1;
      end

      if (regReq.wrEn && hit) begin
         if (!writeUnlocked) begin
            st_d.wrRejected = 1'b1;
         end else begin
            unique case (regReq.addr)
               RAIL_ENABLE_CONTROL_OFS:
                  st_d.railEnable = regReq.wdata & RAIL_ENABLE_WMASK;
               LOCKOUT_THRESHOLD_CONTROL_OFS:
                  st_d.lockout = regReq.wdata & LOCKOUT_WMASK;
               BUCK_STROBE_ASSIGN_A_OFS:
                  st_d.strobeAssign = regReq.wdata & STROBE_ASSIGN_WMASK;
               default: ;
            endcase
         end
      end

      // Gated rails need both the pin and their bit; a sequencer-owned buck
      // also turns on at its strobe step while the pin is high.
      st_d.railOn.switchAOn = pinHigh && st_q.railEnable[SWITCH_A_BIT];
      st_d.railOn.switchBOn = pinHigh && st_q.railEnable[SWITCH_B_BIT];
      st_d.railOn.buckAOn   = pinHigh && (st_q.railEnable[BUCK_A_BIT]
                              || (buckAOwned && buckASeqOn));
      st_d.railOn.buckBOn   = pinHigh && (st_q.railEnable[BUCK_B_BIT]
                              || (buckBOwned && buckBSeqOn));
      st_d.railOn.buckCOn   = pinHigh && st_q.railEnable[BUCK_C_BIT];
      st_d.railOn.linregAOn = st_q.railEnable[LINREG_A_BIT];
      st_d.railOn.linregBOn = st_q.railEnable[LINREG_B_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q              <= '0;
         st_q.railEnable   <= RAIL_ENABLE_RESET;
         st_q.lockout      <= LOCKOUT_RESET;
         st_q.strobeAssign <= STROBE_ASSIGN_RESET;
      end else if (clkEn) begin
         st_q <= st_d;
      end
   end

   assign rdData              = st_q.rdData;
   assign rdValid             = st_q.rdValid;
   assign wrRejected          = st_q.wrRejected;
   assign railOn              = st_q.railOn;
   assign lockoutThresholdSel = st_q.lockout[THRESH_LSB +: THRESH_W];

   property p_locked_write_ignored;
      @(posedge sys_clk) disable iff (reset)
         (clkEn && regReq.wrEn && !writeUnlocked && regReq.addr == RAIL_ENABLE_CONTROL_OFS)
         |=> $stable(st_q.railEnable) && wrRejected;
   endproperty
   a_locked_write_ignored: assert property (p_locked_write_ignored)
      else $error("locked write took");

   property p_enable_write;
      @(posedge sys_clk) disable iff (reset)
         (clkEn && regReq.wrEn && writeUnlocked && regReq.addr == RAIL_ENABLE_CONTROL_OFS)
         |=> st_q.railEnable == ($past(regReq.wdata) & RAIL_ENABLE_WMASK);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write lost");

   property p_bit7_zero;
      @(posedge sys_clk) disable iff (reset) !st_q.railEnable[7];
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("reserved bit set");

   property p_switch_a_gate;
      @(posedge sys_clk) disable iff (reset)
         clkEn |=> railOn.switchAOn == $past(st_q.pinSync && st_q.railEnable[SWITCH_A_BIT]);
   endproperty
   a_switch_a_gate: assert property (p_switch_a_gate) else $error("switch A gating");

   property p_switch_b_gate;
      @(posedge sys_clk) disable iff (reset)
         railOn.switchBOn |-> $past(st_q.pinSync);
   endproperty
   a_switch_b_gate: assert property (p_switch_b_gate) else $error("switch B without pin");

   property p_buck_c_gate;
      @(posedge sys_clk) disable iff (reset)
         railOn.buckCOn |-> $past(st_q.pinSync) && $past(st_q.railEnable[BUCK_C_BIT]);
   endproperty
   a_buck_c_gate: assert property (p_buck_c_gate) else $error("buck C gating");

   property p_linreg_direct;
      @(posedge sys_clk) disable iff (reset)
         clkEn |=> railOn.linregAOn == $past(st_q.railEnable[LINREG_A_BIT]);
   endproperty
   a_linreg_direct: assert property (p_linreg_direct) else $error("linreg A mismatch");

   property p_lockout_read;
      @(posedge sys_clk) disable iff (reset)
         (clkEn && regReq.rdEn && regReq.addr == LOCKOUT_THRESHOLD_CONTROL_OFS)
         |=> rdValid && rdData[7:3] == 5'h00;
   endproperty
   a_lockout_read: assert property (p_lockout_read) else $error("lockout reserved set");

   property p_strobe_read;
      @(posedge sys_clk) disable iff (reset)
         (clkEn && regReq.rdEn && regReq.addr == BUCK_STROBE_ASSIGN_A_OFS)
         |=> !rdData[7] && !rdData[3];
   endproperty
   a_strobe_read: assert property (p_strobe_read) else $error("strobe reserved set");
endmodule : rail_enable_sequence_regs

// ==== core/rail_regs_pkg.sv ====
/*
 Constants, field layouts and carriers for the rail enable register bank.
 Assumes an upstream serial-bus front end that delivers decoded byte accesses.
*/
package rail_regs_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned SLOT_W = 3;
   localparam int unsigned RAIL_N = 7;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] byte_t;
   typedef logic [SLOT_W-1:0] slot_t;
   localparam addr_t RAIL_ENABLE_CONTROL_OFS       = 8'h16;
   localparam addr_t LOCKOUT_THRESHOLD_CONTROL_OFS = 8'h18;
   localparam addr_t BUCK_STROBE_ASSIGN_A_OFS      = 8'h19;
   localparam byte_t RAIL_ENABLE_RESET   = 8'h00;
   localparam byte_t LOCKOUT_RESET       = 8'h00;
   localparam byte_t STROBE_ASSIGN_RESET = 8'h00;
   // Writable masks; reserved read-only bits are outside them
   localparam byte_t RAIL_ENABLE_WMASK   = 8'h7f;
   localparam byte_t LOCKOUT_WMASK       = 8'h07;
   localparam byte_t STROBE_ASSIGN_WMASK = 8'h77;
   localparam int unsigned SWITCH_A_BIT = 6;
   localparam int unsigned SWITCH_B_BIT = 5;
   localparam int unsigned BUCK_A_BIT   = 4;
   localparam int unsigned BUCK_B_BIT   = 3;
   localparam int unsigned BUCK_C_BIT   = 2;
   localparam int unsigned LINREG_A_BIT = 1;
   localparam int unsigned LINREG_B_BIT = 0;
   localparam int unsigned SLOT_A_LSB   = 4;
   localparam int unsigned SLOT_B_LSB   = 0;
   localparam int unsigned THRESH_LSB   = 0;
   localparam int unsigned THRESH_W     = 2;
   localparam slot_t SLOT_NONE = 3'h0;
   // Lockout thresholds in millivolts
   localparam int unsigned UVLO_MV_0 = 2730;
   localparam int unsigned UVLO_MV_1 = 2890;
   localparam int unsigned UVLO_MV_2 = 3180;
   localparam int unsigned UVLO_MV_3 = 3300;

   typedef struct packed {
      logic  wrEn;
      logic  rdEn;
      addr_t addr;
      byte_t wdata;
   } reg_req_s;

   typedef struct packed {
      logic switchAOn;
      logic switchBOn;
      logic buckAOn;
      logic buckBOn;
      logic buckCOn;
      logic linregAOn;
      logic linregBOn;
   } rail_on_s;
endpackage : rail_regs_pkg

// ==== core/strobe_slot_gate.sv ====
/*
 Sequencer gate for one buck rail: turns the rail on when the running strobe
 step reaches the assigned slot. Assumes strobe steps come from same-clock logic.
*/
`timescale 1ns/1ps
module strobe_slot_gate
   import rail_regs_pkg::*;
(
   // Clock and control
   input  wire logic               sys_clk,
   input  wire logic               reset,
   input  wire logic               clkEn,
   // Sequencer
   input  wire logic               seqRestart,
   input  wire logic               strobeValid,
   input  wire rail_regs_pkg::slot_t strobeStep,
   input  wire rail_regs_pkg::slot_t slot,
   // Result
   output logic                    seqOn,
   output logic                    seqOwned
);
   typedef struct packed {
      logic on;
   } gate_s;
   gate_s st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (slot == SLOT_NONE) begin
         st_d.on = 1'b0;
      end else if (seqRestart) begin
         st_d.on = 1'b0;
      end else if (strobeValid && strobeStep == slot) begin
         st_d.on = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_q <= '0;
      end else if (clkEn) begin
         st_q <= st_d;
      end
   end

   assign seqOn    = st_q.on;
   assign seqOwned = (slot != SLOT_NONE);

   property p_slot_fires;
      @(posedge sys_clk) disable iff (reset)
         (clkEn && strobeValid && !seqRestart && slot != SLOT_NONE && strobeStep == slot)
         |=> seqOn;
   endproperty
   a_slot_fires: assert property (p_slot_fires) else $error("slot strobe missed");

   property p_unassigned_off;
      @(posedge sys_clk) disable iff (reset)
         (clkEn && $stable(slot) && slot == SLOT_NONE) |=> !seqOn;
   endproperty
   a_unassigned_off: assert property (p_unassigned_off) else $error("unowned rail on");
endmodule : strobe_slot_gate

// ==== test/host_model.sv ====
/*
 Host-side model that issues single-byte register accesses and holds the
 write-unlock level. Assumes the bank answers exactly one cycle after taking.
*/
`timescale 1ns/1ps
module host_model
   import rail_regs_pkg::*;
(
   // Clock
   input  wire logic                   sys_clk,
   // Register access
   output rail_regs_pkg::reg_req_s     regReq,
   output logic                        writeUnlocked,
   input  wire rail_regs_pkg::byte_t   rdData,
   input  wire logic                   rdValid,
   input  wire logic                   wrRejected
);
   import rail_regs_pkg::*;
   initial begin
      regReq = '0;
      writeUnlocked = 1'b0;
   end
   // Unlock must precede writes; a locked write is issued only to be refused
   task automatic unlock(input logic v);
      @(posedge sys_clk);
      writeUnlocked <= v;
   endtask : unlock
   task automatic access(input logic isWr, input addr_t a, input byte_t d,
                         output byte_t rd, output logic rej);
      @(posedge sys_clk);
      regReq <= '{wrEn: isWr, rdEn: !isWr, addr: a, wdata: d};
      @(posedge sys_clk);
      // Released fields show the inverse so stale values cannot pass
      regReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
      #1;
      rd = (rdValid === 1'b1) ? rdData : 8'hxx;
      rej = wrRejected;
   endtask : access
endmodule : host_model

// ==== test/testbench.sv ====
/*
 Self-checking bench for the rail register bank: register tasks, pin gating
 and strobe slots. Assumes the host model file is compiled before this one.
*/
`timescale 1ns/1ps
module testbench;
   import rail_regs_pkg::*;
   logic       sys_clk, reset, clkEn, seqRestart, strobeValid, power_request_pin;
   logic       writeUnlocked, rdValid, wrRejected, rej;
   slot_t      strobeStep;
   reg_req_s   regReq;
   byte_t      rdData, got;
   rail_on_s   railOn;
   logic [1:0] lockoutThresholdSel;
   int         fail_count = 0;
   int         n_compared = 0;

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   host_model u_host_model(.sys_clk(sys_clk), .regReq(regReq), .writeUnlocked(writeUnlocked),
      .rdData(rdData), .rdValid(rdValid), .wrRejected(wrRejected));
   rail_enable_sequence_regs u_rail_enable_sequence_regs(.sys_clk(sys_clk), .reset(reset),
      .clkEn(clkEn), .regReq(regReq), .writeUnlocked(writeUnlocked), .rdData(rdData),
      .rdValid(rdValid), .wrRejected(wrRejected), .seqRestart(seqRestart),
      .strobeValid(strobeValid), .strobeStep(strobeStep),
      .power_request_pin(power_request_pin), .railOn(railOn),
      .lockoutThresholdSel(lockoutThresholdSel));

   task automatic chk(input byte_t g, input byte_t e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input addr_t a, input byte_t d, input logic expRej);
      u_host_model.access(1'b1, a, d, got, rej);
      chk({7'h00, rej}, {7'h00, expRej});
   endtask : wr
   task automatic rd(input addr_t a, input byte_t e);
      u_host_model.access(1'b0, a, 8'h00, got, rej);
      chk(got, e);
   endtask : rd
   // Pin path is two sync flops plus the output flop
   task automatic settle;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask : settle
   task automatic strobe(input int s);
      @(posedge sys_clk);
      strobeValid <= 1'b1;
      strobeStep <= slot_t'(s);
      @(posedge sys_clk);
      strobeValid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : strobe
   task automatic print_verdict;
      $display("counts: compared=%0d mismatches=%0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      #100us;
      fail_count++;
      $display("watchdog expired");
      print_verdict();
   end

   initial begin
      reset = 1'b1;
      clkEn = 1'b1;
      seqRestart = 1'b0;
      strobeValid = 1'b0;
      strobeStep = 3'h0;
      power_request_pin = 1'b0;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      rd(8'h16, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h19, 8'h00);
      chk({1'b0, railOn}, 8'h00);
      $display("test reset_values done");
      wr(8'h16, 8'hff, 1'b1);
      rd(8'h16, 8'h00);
      u_host_model.unlock(1'b1);
      wr(8'h16, 8'hff, 1'b0);
      rd(8'h16, 8'h7f);
      // An unmapped offset must answer a read with zero and must not alias onto the bank
      wr(8'h17, 8'h55, 1'b0);
      rd(8'h17, 8'h00);
      rd(8'h16, 8'h7f);
      settle();
      chk({1'b0, railOn}, 8'h03);
      @(posedge sys_clk);
      power_request_pin <= 1'b1;
      settle();
      chk({1'b0, railOn}, 8'h7f);
      for (int i = 0; i < 7; i++) begin
         wr(8'h16, 8'h01 << i, 1'b0);
         settle();
         chk({1'b0, railOn}, 8'h01 << i);
      end
      $display("test rail_enables done");
      for (int c = 0; c < 4; c++) begin
         wr(8'h18, {6'h3f, 2'(c)}, 1'b0);
         rd(8'h18, {6'h01, 2'(c)});
         chk({6'h00, lockoutThresholdSel}, {6'h00, 2'(c)});
      end
      $display("test lockout done");
      wr(8'h19, 8'hff, 1'b0);
      rd(8'h19, 8'h77);
      wr(8'h16, 8'h00, 1'b0);
      for (int k = 0; k < 8; k++) begin
         // Buck B takes the mirrored slot so both fields see every code
         wr(8'h19, {1'b0, 3'(k), 1'b0, 3'((8 - k) % 8)}, 1'b0);
         @(posedge sys_clk);
         seqRestart <= 1'b1;
         @(posedge sys_clk);
         seqRestart <= 1'b0;
         for (int s = 1; s < 8; s++) begin
            strobe(s);
            chk({6'h00, railOn.buckAOn, railOn.buckBOn},
                {6'h00, k != 0 && s >= k, k != 0 && s >= 8 - k});
         end
      end
      @(posedge sys_clk);
      power_request_pin <= 1'b0;
      settle();
      chk({7'h00, railOn.buckAOn}, 8'h00);
      $display("test strobe_slots done");
      // Enable low must freeze the pin synchroniser and the rail outputs
      @(posedge sys_clk);
      clkEn <= 1'b0;
      power_request_pin <= 1'b1;
      settle();
      chk({6'h00, railOn.buckAOn, railOn.buckBOn}, 8'h00);
      @(posedge sys_clk);
      clkEn <= 1'b1;
      settle();
      chk({6'h00, railOn.buckAOn, railOn.buckBOn}, 8'h03);
      $display("test clock_enable done");
      // A reset in mid-run must return every register and rail to zero
      wr(8'h16, 8'h7f, 1'b0);
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(8'h16, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h19, 8'h00);
      chk({1'b0, railOn}, 8'h00);
      chk({6'h00, lockoutThresholdSel}, 8'h00);
      $display("test midrun_reset done");
      print_verdict();
   end
endmodule : testbench
